// [rtl/tcmv_channel.sv]
// timer channel mode decode, value register and ahb-lite register slave
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tcmv_channel (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        bdm_active,
  input  wire logic        chan_pin_in,
  input  wire logic [15:0] cnt_value,
  input  wire logic        cnt_tick,
  input  wire logic        cnt_up,
  input  wire logic [15:0] modulo_value,
  output logic             chan_pin_out,
  output logic             chan_pin_oe_n,
  output logic             chan_gpio_release,
  output logic             cnt_updown
);
  typedef struct packed {
    logic        hrdy;
    logic        hresp;
    logic [31:0] hrdata;
    logic        dph;
    logic        dwr;
    logic [7:0]  daddr;
    logic [1:0]  clks;
    logic        center_pwm_select;
    logic [3:0]  csc;
    logic [15:0] val;
    logic [15:0] rbuf;
    logic        rlat;
    logic        rfirst_hi;
    logic [15:0] wbuf;
    logic        whi;
    logic        wlo;
    logic        wpend;
    logic        pin_out;
    logic        pin_oe_n;
    logic        gpio_rel;
    logic        updown;
  } tcmv_ch_s;

  tcmv_ch_s       st_ff;
  tcmv_ch_s       nxt_st;
  tcmv_cap_if     cap_if ();

  // ======================================================
  // decoding helpers
  function automatic tcmv_pkg::tcmv_mode_e chan_mode(input logic center_pwm_select, input logic [3:0] csc);
    if (center_pwm_select) begin
      chan_mode = tcmv_pkg::TCMV_CENTER_PWM;
    end else if (csc[tcmv_pkg::MSB_BIT-2]) begin
      chan_mode = tcmv_pkg::TCMV_EDGE_PWM;
    end else if (csc[tcmv_pkg::MSA_BIT-2]) begin
      chan_mode = tcmv_pkg::TCMV_COMPARE;
    end else begin
      chan_mode = tcmv_pkg::TCMV_CAPTURE;
    end
  endfunction

  function automatic logic [1:0] els_of(input logic [3:0] csc);
    els_of = csc[tcmv_pkg::ELS_LSB-2 +: 2];
  endfunction

  tcmv_pkg::tcmv_mode_e mode;
  logic [1:0]           els;
  logic                 is_pwm;
  logic [15:0]          step_from;
  logic                 ld_ok;
  logic                 oc_match;
  logic                 pwm_lvl;
  logic [31:0]          rd;
  logic [7:0]           wb;
  logic                 hi;

  assign mode   = chan_mode(st_ff.center_pwm_select, st_ff.csc);
  assign els    = els_of(st_ff.csc);
  assign is_pwm = (mode == tcmv_pkg::TCMV_EDGE_PWM) || (mode == tcmv_pkg::TCMV_CENTER_PWM);

  // ======================================================
  // capture unit
  assign cap_if.edge_sel = els;
  assign cap_if.cap_en   = (mode == tcmv_pkg::TCMV_CAPTURE);

  tcmv_pin_cap u_pin_cap (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pin_in  (chan_pin_in),
    .cap     (cap_if.cap)
  );

  // ======================================================
  // load timing of buffered compare value
  always_comb begin
    step_from = (modulo_value == 16'h0000) ? tcmv_pkg::FREE_STEP : 16'(modulo_value - 16'h0001);
    ld_ok     = 1'b0;
    unique case (mode)
      tcmv_pkg::TCMV_COMPARE: begin
        ld_ok = cnt_tick;
      end
      tcmv_pkg::TCMV_EDGE_PWM, tcmv_pkg::TCMV_CENTER_PWM: begin
        ld_ok = cnt_tick && cnt_up && (cnt_value == step_from);
      end
      tcmv_pkg::TCMV_CAPTURE: begin
        ld_ok = 1'b0;
      end
    endcase
    oc_match = cnt_tick && (cnt_value == st_ff.val);
    pwm_lvl  = els[0] ? (cnt_value >= st_ff.val) : (cnt_value < st_ff.val);
  end

  // ======================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    rd     = 32'h0000_0000;
    wb     = hwdata[7:0];
    hi     = (st_ff.daddr == tcmv_pkg::VALH_OFF);

    // input capture
    if (mode == tcmv_pkg::TCMV_CAPTURE && cap_if.cap_pulse) begin
      nxt_st.val = cnt_value;
    end

    // deferred load of a completed pair
    if (st_ff.wpend && ld_ok && !bdm_active) begin
      nxt_st.val   = st_ff.wbuf;
      nxt_st.wpend = 1'b0;
    end

    // address phase
    if (hsel && htrans[1] && hready) begin
      nxt_st.dph   = 1'b1;
      nxt_st.dwr   = hwrite;
      nxt_st.daddr = haddr[7:0];
      nxt_st.hrdy  = 1'b0;
    end

    // data phase
    if (st_ff.dph) begin
      nxt_st.dph  = 1'b0;
      nxt_st.hrdy = 1'b1;
      if (st_ff.dwr) begin
        unique case (st_ff.daddr)
          tcmv_pkg::TSC_OFF: begin
            nxt_st.clks  = wb[tcmv_pkg::CLKS_LSB +: 2];
            nxt_st.center_pwm_select = wb[tcmv_pkg::CENTER_PWM_SELECT_BIT];
          end
          tcmv_pkg::CSC_OFF: begin
            nxt_st.csc   = wb[tcmv_pkg::MSB_BIT:tcmv_pkg::ELS_LSB];
            nxt_st.rlat  = 1'b0;
            nxt_st.whi   = 1'b0;
            nxt_st.wlo   = 1'b0;
            nxt_st.wpend = 1'b0;
          end
          tcmv_pkg::VALH_OFF, tcmv_pkg::VALL_OFF: begin
            if (mode == tcmv_pkg::TCMV_CAPTURE) begin
              nxt_st.val = nxt_st.val;
            end else if (bdm_active) begin
              if (hi) begin
                nxt_st.val[15:8] = wb;
              end else begin
                nxt_st.val[7:0] = wb;
              end
            end else begin
              if (hi) begin
                nxt_st.wbuf[15:8] = wb;
              end else begin
                nxt_st.wbuf[7:0] = wb;
              end
              if ((hi && st_ff.wlo) || (!hi && st_ff.whi)) begin
                nxt_st.whi = 1'b0;
                nxt_st.wlo = 1'b0;
                if (st_ff.clks == tcmv_pkg::CLKS_OFF) begin
                  nxt_st.val   = hi ? {wb, st_ff.wbuf[7:0]} : {st_ff.wbuf[15:8], wb};
                  nxt_st.wpend = 1'b0;
                end else begin
                  nxt_st.wpend = 1'b1;
                end
              end else if (hi) begin
                nxt_st.whi = 1'b1;
              end else begin
                nxt_st.wlo = 1'b1;
              end
            end
          end
          default: begin
            nxt_st.hrdy = 1'b1;
          end
        endcase
      end else begin
        unique case (st_ff.daddr)
          tcmv_pkg::TSC_OFF: begin
            rd[tcmv_pkg::CLKS_LSB +: 2]  = st_ff.clks;
            rd[tcmv_pkg::CENTER_PWM_SELECT_BIT]      = st_ff.center_pwm_select;
          end
          tcmv_pkg::CSC_OFF: begin
            rd[tcmv_pkg::MSB_BIT:tcmv_pkg::ELS_LSB] = st_ff.csc;
          end
          tcmv_pkg::VALH_OFF, tcmv_pkg::VALL_OFF: begin
            if (bdm_active || mode != tcmv_pkg::TCMV_CAPTURE) begin
              rd[7:0] = hi ? st_ff.val[15:8] : st_ff.val[7:0];
            end else if (!st_ff.rlat) begin
              rd[7:0]          = hi ? st_ff.val[15:8] : st_ff.val[7:0];
              nxt_st.rbuf      = st_ff.val;
              nxt_st.rlat      = 1'b1;
              nxt_st.rfirst_hi = hi;
            end else begin
              rd[7:0] = hi ? st_ff.rbuf[15:8] : st_ff.rbuf[7:0];
              if (hi != st_ff.rfirst_hi) begin
                nxt_st.rlat = 1'b0;
              end
            end
          end
          tcmv_pkg::STAT_OFF: begin
            rd[0] = st_ff.pin_out;
            rd[1] = cap_if.pin_level;
            rd[2] = st_ff.whi;
            rd[3] = st_ff.wlo;
            rd[4] = st_ff.wpend;
            rd[5] = st_ff.rlat;
            rd[6] = st_ff.gpio_rel;
            rd[8 +: 2] = mode;
          end
          default: begin
            rd = 32'h0000_0000;
          end
        endcase
        nxt_st.hrdata = rd;
      end
    end

    // pin output
    unique case (mode)
      tcmv_pkg::TCMV_COMPARE: begin
        if (oc_match) begin
          unique case (els)
            2'h1: nxt_st.pin_out = ~st_ff.pin_out;
            2'h2: nxt_st.pin_out = 1'b0;
            2'h3: nxt_st.pin_out = 1'b1;
            2'h0: nxt_st.pin_out = st_ff.pin_out;
          endcase
        end
      end
      tcmv_pkg::TCMV_EDGE_PWM, tcmv_pkg::TCMV_CENTER_PWM: begin
        nxt_st.pin_out = pwm_lvl;
      end
      tcmv_pkg::TCMV_CAPTURE: begin
        nxt_st.pin_out = st_ff.pin_out;
      end
    endcase
    nxt_st.gpio_rel = (els == tcmv_pkg::ELS_PIN_OFF);
    nxt_st.pin_oe_n = (els == tcmv_pkg::ELS_PIN_OFF) || (mode == tcmv_pkg::TCMV_CAPTURE) ||
                      (is_pwm && els == 2'h0);
    nxt_st.updown   = st_ff.center_pwm_select;
  end

  // ======================================================
  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff          <= '0;
      st_ff.hrdy     <= 1'b1;
      st_ff.clks     <= tcmv_pkg::CLKS_RST;
      st_ff.csc      <= tcmv_pkg::CSC_RST;
      st_ff.val      <= tcmv_pkg::VAL_RST;
      st_ff.pin_oe_n <= 1'b1;
      st_ff.gpio_rel <= 1'b1;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ======================================================
  // outputs
  assign hrdata            = st_ff.hrdata;
  assign hreadyout         = st_ff.hrdy;
  assign hresp             = st_ff.hresp;
  assign chan_pin_out      = st_ff.pin_out;
  assign chan_pin_oe_n     = st_ff.pin_oe_n;
  assign chan_gpio_release = st_ff.gpio_rel;
  assign cnt_updown        = st_ff.updown;
endmodule // tcmv_channel

// [rtl/tcmv_pkg.sv]
// constants, field layout and modes of the timer channel mode/value block
package tcmv_pkg;
  // ======================================================
  // register offsets (byte addresses)
  localparam logic [7:0]  TSC_OFF      = 8'h00;
  localparam logic [7:0]  CSC_OFF      = 8'h04;
  localparam logic [7:0]  VALH_OFF     = 8'h08;
  localparam logic [7:0]  VALL_OFF     = 8'h0c;
  localparam logic [7:0]  STAT_OFF     = 8'h10;
  // ======================================================
  // field positions
  localparam int          CLKS_LSB     = 0;
  localparam int          CENTER_PWM_SELECT_BIT    = 5;
  localparam int          ELS_LSB      = 2;
  localparam int          MSA_BIT      = 4;
  localparam int          MSB_BIT      = 5;
  // ======================================================
  // reset values and counter limits
  localparam logic [15:0] VAL_RST      = 16'h0000;
  localparam logic [1:0]  CLKS_RST     = 2'h0;
  localparam logic [3:0]  CSC_RST      = 4'h0;
  localparam logic [15:0] FREE_STEP    = 16'hfffe;
  localparam logic [1:0]  CLKS_OFF     = 2'h0;
  localparam logic [1:0]  ELS_PIN_OFF  = 2'h0;
  // ======================================================
  // channel modes
  typedef enum logic [1:0] {
    TCMV_CAPTURE,
    TCMV_COMPARE,
    TCMV_EDGE_PWM,
    TCMV_CENTER_PWM
  } tcmv_mode_e;
endpackage

// [rtl/tcmv_cap_if.sv]
// capture path signals between channel core and pin capture unit
`timescale 1ns/1ps
interface tcmv_cap_if;
  logic [1:0] edge_sel;
  logic       cap_en;
  logic       pin_level;
  logic       cap_pulse;
  modport ctrl (output edge_sel, output cap_en, input pin_level, input cap_pulse);
  modport cap  (input edge_sel, input cap_en, output pin_level, output cap_pulse);
endinterface

// [rtl/tcmv_pin_cap.sv]
// channel pin synchroniser and capture edge detector
`timescale 1ns/1ps
module tcmv_pin_cap (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic pin_in,
  tcmv_cap_if.cap   cap
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic pulse;
  } tcmv_pc_s;

  tcmv_pc_s st_ff;
  tcmv_pc_s nxt_st;

  // ======================================================
  // edge selection
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = pin_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev  = st_ff.sync2;
    nxt_st.pulse = cap.cap_en & ((st_ff.sync2 & ~st_ff.prev & cap.edge_sel[0]) |
                                 (~st_ff.sync2 & st_ff.prev & cap.edge_sel[1]));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign cap.pin_level = st_ff.sync2;
  assign cap.cap_pulse = st_ff.pulse;
endmodule // tcmv_pin_cap

// [dv/tcmv_pin_model.sv]
// channel pin partner: outside driver and wire resolution
`timescale 1ns/1ps
module tcmv_pin_model (
  input  wire logic ext_level,
  input  wire logic chan_pin_out,
  input  wire logic chan_pin_oe_n,
  output logic      chan_pin_in
);
  // ==========
  // wire level
  assign chan_pin_in = chan_pin_oe_n ? ext_level : chan_pin_out;
endmodule // tcmv_pin_model

// [dv/tcmv_asserts.sv]
// port checks for the channel block
`timescale 1ns/1ps
module tcmv_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        chan_gpio_release,
  input wire logic        chan_pin_oe_n,
  input wire logic        cnt_updown
);
  // ==========
  // helpers
  logic acc, wt_ff, wc_ff, ud_ff, rl_ff;
  assign acc = hsel && htrans[1] && hready && ce;
  always_ff @(posedge clk) begin
    wt_ff <= !sys_rst && acc && hwrite && haddr[7:0] == tcmv_pkg::TSC_OFF;
    wc_ff <= !sys_rst && acc && hwrite && haddr[7:0] == tcmv_pkg::CSC_OFF;
    if (wt_ff) begin
      ud_ff <= hwdata[5];
    end
    if (wc_ff) begin
      rl_ff <= hwdata[3:2] == 2'b00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // assertions
  a_ready_one_low: assert property (acc |=> !hreadyout ##1 hreadyout)
    else $error("ready pulse wrong");
  a_ready_cause: assert property (!hreadyout |-> $past(acc))
    else $error("ready low without request");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(!hreadyout))
    else $error("read data moved outside data phase");
  a_release_undriven: assert property (chan_gpio_release |-> chan_pin_oe_n)
    else $error("released pin still driven");
  a_release_follow: assert property (wc_ff |-> ##2 chan_gpio_release == rl_ff)
    else $error("release flag wrong");
  a_updown_follow: assert property (wt_ff |-> ##2 cnt_updown == ud_ff)
    else $error("count direction wrong");
  a_reset_idle: assert property ($past(sys_rst) |-> chan_gpio_release && chan_pin_oe_n && !cnt_updown
    && hreadyout && hrdata == 32'h0)
    else $error("reset state wrong");
endmodule // tcmv_asserts

// [dv/tcmv_channel_tb.sv]
// self-checking bench for the channel block
`timescale 1ns/1ps
module tcmv_channel_tb;
  localparam logic [7:0] TS = tcmv_pkg::TSC_OFF;
  localparam logic [7:0] CS = tcmv_pkg::CSC_OFF;
  localparam logic [7:0] HI = tcmv_pkg::VALH_OFF;
  localparam logic [7:0] LO = tcmv_pkg::VALL_OFF;
  localparam logic [7:0] ST = tcmv_pkg::STAT_OFF;
  logic        clk, sys_rst, ce, hsel, hwrite, hready, bdm_active, ext_level, cnt_tick, cnt_up;
  logic        hreadyout, hresp, chan_pin_in, chan_pin_out, chan_pin_oe_n, chan_gpio_release, cnt_updown, p;
  logic [1:0]  htrans;
  logic [15:0] cnt_value, modulo_value, cv;
  logic [31:0] haddr, hwdata, hrdata, q;
  int          errors, check_count;
  assign hready = hreadyout;
  always #2 clk = ~clk;
  tcmv_channel u_dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bdm_active(bdm_active), .chan_pin_in(chan_pin_in), .cnt_value(cnt_value), .cnt_tick(cnt_tick),
    .cnt_up(cnt_up), .modulo_value(modulo_value), .chan_pin_out(chan_pin_out),
    .chan_pin_oe_n(chan_pin_oe_n), .chan_gpio_release(chan_gpio_release), .cnt_updown(cnt_updown)
  );
  tcmv_pin_model u_pin (
    .ext_level(ext_level), .chan_pin_out(chan_pin_out), .chan_pin_oe_n(chan_pin_oe_n), .chan_pin_in(chan_pin_in)
  );
  // ==========
  // tasks
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pc(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      errors++;
      conclude;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic tick(input logic [15:0] v);
    @(posedge clk);
    cnt_value <= v;
    cnt_tick <= 1'b1;
    @(posedge clk);
    cnt_tick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic pin(input logic l, input logic [15:0] v);
    @(posedge clk);
    cnt_value <= v;
    ext_level <= l;
    repeat (6) @(posedge clk);
  endtask
  // ==========
  // sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    bdm_active = 1'b0;
    ext_level = 1'b0;
    cnt_value = 16'h0;
    cnt_tick = 1'b0;
    cnt_up = 1'b1;
    modulo_value = 16'h0;
    errors = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rc(HI, 32'h0);
    rc(LO, 32'h0);
    rc(TS, 32'h0);
    wr(8'h18, 32'hff);
    rc(8'h18, 32'h0);
    $display("test reset done");
    wr(CS, 32'h14);
    wr(HI, 32'h12);
    rc(HI, 32'h0);
    wr(LO, 32'h34);
    rc(HI, 32'h12);
    wr(HI, 32'h55);
    wr(CS, 32'h14);
    wr(LO, 32'h66);
    rc(LO, 32'h34);
    wr(HI, 32'h77);
    rc(HI, 32'h77);
    rc(LO, 32'h66);
    wr(TS, 32'h01);
    wr(LO, 32'h0);
    wr(HI, 32'h40);
    rc(HI, 32'h77);
    tick(16'h0100);
    rc(HI, 32'h40);
    $display("test buffering done");
    for (int e = 1; e < 4; e++) begin
      wr(CS, {26'h0, 2'b01, e[1:0], 2'b00});
      p = chan_pin_in;
      tick(16'h4000);
      pc(chan_pin_in, e == 1 ? ~p : e[0]);
    end
    for (int m = 0; m < 4; m++) begin
      wr(CS, {26'h0, m[1:0], 4'h0});
      @(posedge clk);
      pc(chan_gpio_release, 1'b1);
    end
    wr(CS, 32'h28);
    tick(16'h1000);
    pc(chan_pin_in, 1'b1);
    tick(16'h5000);
    pc(chan_pin_in, 1'b0);
    wr(CS, 32'h24);
    tick(16'h1000);
    pc(chan_pin_in, 1'b0);
    wr(HI, 32'h20);
    wr(LO, 32'h0);
    tick(16'h1000);
    rc(HI, 32'h40);
    tick(16'hfffe);
    rc(HI, 32'h20);
    modulo_value <= 16'h8000;
    wr(HI, 32'h30);
    wr(LO, 32'h0);
    tick(16'hfffe);
    rc(HI, 32'h20);
    tick(16'h7fff);
    rc(HI, 32'h30);
    $display("test compare pwm done");
    wr(TS, 32'h21);
    wr(CS, 32'h08);
    @(posedge clk);
    pc(cnt_updown, 1'b1);
    pc(chan_pin_oe_n, 1'b0);
    bus(1'b0, ST, 32'h0);
    chk(q & 32'h300, 32'h300);
    wr(TS, 32'h01);
    bus(1'b0, ST, 32'h0);
    chk(q & 32'h300, 32'h0);
    wr(TS, 32'h0);
    cv = 16'h3000;
    for (int e = 1; e < 4; e++) begin
      wr(CS, {28'h0, e[1:0], 2'b00});
      pin(1'b1, 16'h0100 + 16'(e));
      cv = e[0] ? 16'h0100 + 16'(e) : cv;
      rc(HI, {24'h0, cv[15:8]});
      rc(LO, {24'h0, cv[7:0]});
      pin(1'b0, 16'h0200 + 16'(e));
      cv = e[1] ? 16'h0200 + 16'(e) : cv;
      rc(HI, {24'h0, cv[15:8]});
      rc(LO, {24'h0, cv[7:0]});
    end
    wr(HI, 32'hff);
    rc(HI, 32'h02);
    rc(LO, 32'h03);
    rc(HI, 32'h02);
    pin(1'b1, 16'h0504);
    @(posedge clk);
    bdm_active <= 1'b1;
    rc(LO, 32'h04);
    bdm_active <= 1'b0;
    rc(LO, 32'h03);
    $display("test capture done");
    wr(CS, 32'h14);
    wr(HI, 32'haa);
    bdm_active <= 1'b1;
    wr(LO, 32'hbb);
    rc(LO, 32'hbb);
    rc(HI, 32'h05);
    bdm_active <= 1'b0;
    wr(LO, 32'hcc);
    rc(HI, 32'haa);
    rc(LO, 32'hcc);
    $display("test debug done");
    conclude;
  end
endmodule // tcmv_channel_tb
bind tcmv_channel tcmv_asserts u_chk (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .chan_gpio_release(chan_gpio_release), .chan_pin_oe_n(chan_pin_oe_n), .cnt_updown(cnt_updown)
);
